// >>> uart_pin_mode_power_control.sv
// Pin-level control of a single-channel UART: bus style, power, modem pins
`timescale 1ns/1ps
module uart_pin_mode_power_control (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       bus_style_sel,
    input  wire logic       master_reset_pin,
    input  wire logic       sleep_request,
    input  wire logic       chip_sel_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       ring_n,
    input  wire logic       rx_pin,
    output logic            tx_pin,
    output logic            tx_oe,
    output logic            rts_n,
    output logic            irq_out,
    output logic            irq_oe,
    output logic            osc_enable,
    output logic            host_isolate,
    output logic            low_power,
    output logic            rx_bit,
    input  wire logic       tx_enable
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] s1_q, s2_q, s3_q, s4_q, s5_q, s6_q, s7_q, s8_q;
    logic [7:0] dat1_q, dat2_q;
    logic [2:0] adr1_q, adr2_q;
    logic sel_s, mrst_s, slp_s, cs_n_s, rd_n_s, wr_n_s, ri_s, rx_s;

    always_ff @(posedge mclk)
    begin
        s1_q   <= {s1_q[0], bus_style_sel};
        s2_q   <= {s2_q[0], master_reset_pin};
        s3_q   <= {s3_q[0], sleep_request};   // Pulled low off chip
        s4_q   <= {s4_q[0], chip_sel_n};
        s5_q   <= {s5_q[0], read_strobe_n};
        s6_q   <= {s6_q[0], write_strobe_n};
        s7_q   <= {s7_q[0], ring_n};
        s8_q   <= {s8_q[0], rx_pin};
        dat1_q <= data_in;
        dat2_q <= dat1_q;
        adr1_q <= addr;
        adr2_q <= adr1_q;
    end
    assign mrst_s = s2_q[1];
    assign slp_s  = s3_q[1];
    assign cs_n_s = s4_q[1];
    assign rd_n_s = s5_q[1];
    assign wr_n_s = s6_q[1];
    assign ri_s   = s7_q[1];
    assign rx_s   = s8_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Bus-style strap, captured once after reset
    logic strap_q, strap_d, strap_ok_q, strap_ok_d;
    always_comb
    begin
        strap_ok_d = 1'b1;
        strap_d    = strap_ok_q ? strap_q : s1_q[1];
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            strap_q    <= 1'b1;
            strap_ok_q <= 1'b0;
        end
        else
        begin
            strap_q    <= strap_d;
            strap_ok_q <= strap_ok_d;
        end
    end
    assign sel_s = strap_ok_q ? strap_q : s1_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Power state and internal reset
    uart_pin_pkg::pwr_state_t pwr_q, pwr_d;
    logic pin_rst, int_rst;
    // Reset pin polarity follows the bus style
    assign pin_rst = sel_s ? mrst_s : !mrst_s;

    always_comb
    begin
        case (pwr_q)
            uart_pin_pkg::PWR_RUN:   pwr_d = slp_s ? uart_pin_pkg::PWR_SLEEP : uart_pin_pkg::PWR_RUN;
            uart_pin_pkg::PWR_SLEEP: pwr_d = slp_s ? uart_pin_pkg::PWR_SLEEP : uart_pin_pkg::PWR_WAKE;
            uart_pin_pkg::PWR_WAKE:  pwr_d = slp_s ? uart_pin_pkg::PWR_SLEEP : uart_pin_pkg::PWR_RUN;
            default:                 pwr_d = uart_pin_pkg::PWR_RUN;
        endcase
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
            pwr_q <= uart_pin_pkg::PWR_RUN;
        else
            pwr_q <= pwr_d;
    end
    // Wake state is a one-cycle self reset on the falling request
    assign int_rst      = pin_rst || (pwr_q == uart_pin_pkg::PWR_WAKE);
    assign low_power    = (pwr_q == uart_pin_pkg::PWR_SLEEP);
    assign osc_enable   = !low_power;
    assign host_isolate = low_power;

    ////////////////////////////////////////////////////////////////////////
    // Host bus decode
    logic rd_act, wr_act, wr_prev_q, wr_prev_d, wr_pulse, bus_ok;
    assign bus_ok = !cs_n_s && !low_power && !int_rst;
    always_comb
    begin
        if (sel_s)
        begin
            rd_act = bus_ok && !rd_n_s;   // Separate strobes
            wr_act = bus_ok && !wr_n_s;
        end
        else
        begin
            rd_act = bus_ok && wr_n_s;    // Direction line; read strobe tied high
            wr_act = bus_ok && !wr_n_s;
        end
        wr_prev_d = wr_act;
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
            wr_prev_q <= 1'b0;
        else
            wr_prev_q <= wr_prev_d;
    end
    assign wr_pulse = wr_act && !wr_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] mcr_q, mcr_d, ier_q, ier_d;
    logic       ri_prev_q, ri_prev_d, msi_q, msi_d;
    logic       ri_rise;
    fifo_if     txw ();
    fifo_if     txr ();

    assign ri_rise = ri_s && !ri_prev_q;
    always_comb
    begin
        mcr_d     = mcr_q;
        ier_d     = ier_q;
        ri_prev_d = ri_s;
        msi_d     = msi_q;
        if (wr_pulse && adr2_q == uart_pin_pkg::ADDR_MCR)
            mcr_d = dat2_q;
        if (wr_pulse && adr2_q == uart_pin_pkg::ADDR_IER)
            ier_d = dat2_q;
        if (rd_act && adr2_q == uart_pin_pkg::ADDR_MSR)
            msi_d = 1'b0;
        // Set wins over a clearing read
        if (ri_rise)
            msi_d = 1'b1;
    end
    always_ff @(posedge mclk)
    begin
        if (reset || int_rst)
        begin
            mcr_q     <= uart_pin_pkg::MCR_RESET;
            ier_q     <= uart_pin_pkg::IER_RESET;
            ri_prev_q <= 1'b1;
            msi_q     <= 1'b0;
        end
        else
        begin
            mcr_q     <= mcr_d;
            ier_q     <= ier_d;
            ri_prev_q <= ri_prev_d;
            msi_q     <= msi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data
    logic [7:0] dout_d, dout_q;
    logic       oe_q;
    always_comb
    begin
        case (adr2_q)
            uart_pin_pkg::ADDR_MCR: dout_d = {mcr_q[7], !ri_s, mcr_q[5:0]};
            uart_pin_pkg::ADDR_IER: dout_d = ier_q;
            uart_pin_pkg::ADDR_MSR: dout_d = {1'b0, !ri_s, 5'h00, msi_q};
            default:                dout_d = 8'h00;
        endcase
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            dout_q <= 8'h00;
            oe_q   <= 1'b0;
        end
        else
        begin
            dout_q <= dout_d;
            oe_q   <= rd_act;
        end
    end
    assign data_out = dout_q;
    assign data_oe  = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Transmitter: FIFO plus shift register
    logic [9:0] sh_q, sh_d;
    logic [3:0] nb_q, nb_d;
    logic [4:0] bc_q, bc_d;
    logic       txs;
    assign txw.valid = wr_pulse && adr2_q == uart_pin_pkg::ADDR_DATA;
    assign txw.data  = dat2_q;

    tx_fifo #(
        .WIDTH (uart_pin_pkg::FIFO_WIDTH),
        .DEPTH (uart_pin_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk (mclk),
        .clr (reset || int_rst),
        .wr  (txw),
        .rd  (txr)
    );

    // Shifter drains only when enabled and idle, so the FIFO can fill
    assign txr.ready = tx_enable && (nb_q == 4'h0);
    always_comb
    begin
        sh_d = sh_q;
        nb_d = nb_q;
        bc_d = bc_q;
        if (txr.valid && txr.ready)
        begin
            sh_d = {1'b1, txr.data, 1'b0};
            nb_d = 4'ha;
            bc_d = 5'(uart_pin_pkg::BIT_CYCLES - 1);
        end
        else if (nb_q != 4'h0)
        begin
            if (bc_q == 5'h00)
            begin
                sh_d = {1'b1, sh_q[9:1]};
                nb_d = nb_q - 4'h1;
                bc_d = 5'(uart_pin_pkg::BIT_CYCLES - 1);
            end
            else
                bc_d = bc_q - 5'h01;
        end
    end
    always_ff @(posedge mclk)
    begin
        if (reset || int_rst)
        begin
            sh_q <= 10'h3ff;
            nb_q <= 4'h0;
            bc_q <= 5'h00;
        end
        else
        begin
            sh_q <= sh_d;
            nb_q <= nb_d;
            bc_q <= bc_d;
        end
    end
    // Idle and reset leave the line marking; a low tx_enable only holds off the next frame
    assign txs = (nb_q != 4'h0) ? sh_q[0] : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Modem and serial pins
    logic loop_mode;
    assign loop_mode = mcr_q[uart_pin_pkg::MCR_LOOP_BIT];
    assign rx_bit    = loop_mode ? txs : rx_s;
    assign tx_pin    = loop_mode ? 1'b1 : txs;
    assign tx_oe     = !loop_mode && !low_power;
    assign rts_n     = !mcr_q[uart_pin_pkg::MCR_RTS_BIT];

    // Interrupt pin: active drive, open-source, or open-drain
    logic irq_act;
    assign irq_act = msi_q && ier_q[uart_pin_pkg::IER_MSI_BIT];
    always_comb
    begin
        if (sel_s)
        begin
            irq_out = irq_act;
            irq_oe  = mcr_q[uart_pin_pkg::MCR_INTEN_BIT] || irq_act;
        end
        else
        begin
            irq_out = 1'b0;
            irq_oe  = irq_act;
        end
    end
endmodule

// >>> uart_pin_pkg.sv
// Package with constants for the UART pin-mode and power control block
package uart_pin_pkg;
    // Modem control register field positions
    localparam int MCR_RTS_BIT   = 1;
    localparam int MCR_INTEN_BIT = 5;
    localparam int MCR_RI_BIT    = 6;
    localparam int MCR_LOOP_BIT  = 4;
    localparam int MCR_WIDTH     = 8;
    // Reset values and IER modem-status enable bit position
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam int IER_MSI_BIT    = 3;
    // Register addresses (3-bit host address)
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER  = 3'h1;
    localparam logic [2:0] ADDR_MCR  = 3'h4;
    localparam logic [2:0] ADDR_MSR  = 3'h6;
    // Transmit FIFO shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    // Serial bit time in mclk cycles
    localparam int BIT_CYCLES = 16;
    // Power mode states
    typedef enum logic [1:0]
    {
        PWR_RUN   = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_WAKE  = 2'b10
    } pwr_state_t;
endpackage

// >>> fifo_if.sv
// Valid/ready stream carrier between the control block and its FIFO
`timescale 1ns/1ps
interface fifo_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// >>> tx_fifo.sv
// Parameterised FIFO with registered read data
`timescale 1ns/1ps
module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)(
    input  wire logic clk,
    input  wire logic clr,
    fifo_if.sink      wr,
    fifo_if.src       rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] dout_q, dout_d;
    logic             ov_q, ov_d;
    logic             push, pop, load;

    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd.valid = ov_q;
    assign rd.data  = dout_q;
    assign push = wr.valid && wr.ready;
    assign pop  = ov_q && rd.ready;
    // Output register refills when empty or being drained
    assign load = (cnt_q != '0) && (!ov_q || pop);

    always_comb
    begin
        wp_d   = push ? wp_q + AW'(1) : wp_q;
        rp_d   = load ? rp_q + AW'(1) : rp_q;
        cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        dout_d = load ? mem[rp_q] : dout_q;
        ov_d   = load ? 1'b1 : (pop ? 1'b0 : ov_q);
    end

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            wp_q   <= '0;
            rp_q   <= '0;
            cnt_q  <= '0;
            dout_q <= '0;
            ov_q   <= 1'b0;
        end
        else
        begin
            wp_q   <= wp_d;
            rp_q   <= rp_d;
            cnt_q  <= cnt_d;
            dout_q <= dout_d;
            ov_q   <= ov_d;
        end
        if (push)
            mem[wp_q] <= wr.data;
    end
endmodule

// >>> uart_pin_mode_power_control_assertions.sv
// Port-level checks for the pin-mode and power control block
`timescale 1ns/1ps
module uart_pin_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic bus_style_sel,
    input wire logic master_reset_pin,
    input wire logic sleep_request,
    input wire logic chip_sel_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic data_oe,
    input wire logic tx_pin,
    input wire logic rts_n,
    input wire logic irq_out,
    input wire logic irq_oe,
    input wire logic osc_enable,
    input wire logic host_isolate,
    input wire logic low_power
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    property p_mrst;
        (master_reset_pin == bus_style_sel)[*6] |-> rts_n && tx_pin && !data_oe;
    endproperty
    a_mrst: assert property (p_mrst) else $error("master reset left outputs active");
    property p_sleep_in;
        $rose(sleep_request) |-> ##[1:4] (low_power && !osc_enable && host_isolate);
    endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
    property p_sleep_hold;
        sleep_request[*3] ##0 low_power |=> low_power;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep early");
    property p_wake;
        $fell(low_power) |-> ##[0:3] (rts_n && tx_pin);
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not reset");
    property p_rts_wr;
        $fell(rts_n) |-> $past(!chip_sel_n, 3);
    endproperty
    a_rts_wr: assert property (p_rts_wr) else $error("rts fell without access");
    property p_od;
        !bus_style_sel |-> !(irq_oe && irq_out);
    endproperty
    a_od: assert property (p_od) else $error("open-drain irq drove high");
    property p_cs;
        chip_sel_n[*6] |-> !data_oe;
    endproperty
    a_cs: assert property (p_cs) else $error("read data driven while deselected");
    property p_dir;
        (!bus_style_sel && !write_strobe_n)[*6] |-> !data_oe;
    endproperty
    a_dir: assert property (p_dir) else $error("write direction drove data");
    property p_str;
        (bus_style_sel && read_strobe_n)[*6] |-> !data_oe;
    endproperty
    a_str: assert property (p_str) else $error("data driven without read strobe");
    c_wake: cover property ($fell(low_power));
    c_rts: cover property ($fell(rts_n));
    c_irq: cover property (irq_oe && irq_out);
endmodule
bind uart_pin_mode_power_control uart_pin_checker i_uart_pin_checker (.*);

// >>> serial_far_end.sv
// Far-end serial device and modem model
`timescale 1ns/1ps
module serial_far_end (
    input  wire logic ring_cmd,
    input  wire logic rx_break,
    output logic      ring_n,
    output logic      rx_pin
);
    assign ring_n = !ring_cmd;
    // Line rests high unless a break is commanded
    assign rx_pin = !rx_break;
endmodule

// >>> uart_pin_mode_power_control_test.sv
// Self-checking bench for the pin-mode and power control block
`timescale 1ns/1ps
module uart_pin_mode_power_control_test;
    logic       mclk = 0;
    logic       reset = 1;
    logic       style = 1;
    logic       mrst = 0;
    logic       sleep = 0;
    logic       cs_n = 1;
    logic       rd_n = 1;
    logic       wr_n = 1;
    logic       tx_en = 1;
    logic       ring_cmd = 0;
    logic       rx_break = 0;
    logic       lb = 0;
    logic [2:0] addr = 0;
    logic [7:0] din = 0;
    logic [7:0] dout;
    logic [7:0] q;
    logic       data_oe, ring_n, rx_pin, tx_pin, tx_oe, rts_n;
    logic       irq_out, irq_oe, osc_enable, host_isolate, low_power, rx_bit;
    wire logic  ser = lb ? rx_bit : tx_pin;
    int         bad_count = 0;
    int         checks_done = 0;
    int         cyc = 0;
    always #50 mclk = ~mclk;
    uart_pin_mode_power_control i_uart_pin_mode_power_control (
        .mclk(mclk), .reset(reset), .bus_style_sel(style), .master_reset_pin(mrst),
        .sleep_request(sleep), .chip_sel_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .addr(addr), .data_in(din), .data_out(dout), .data_oe(data_oe), .ring_n(ring_n),
        .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe), .rts_n(rts_n), .irq_out(irq_out),
        .irq_oe(irq_oe), .osc_enable(osc_enable), .host_isolate(host_isolate),
        .low_power(low_power), .rx_bit(rx_bit), .tx_enable(tx_en));
    serial_far_end i_serial_far_end (.ring_cmd(ring_cmd), .rx_break(rx_break), .ring_n(ring_n), .rx_pin(rx_pin));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task bus(input logic cs, input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        din = d;
        cs_n = !cs;
        wr_n = !wr;
        rd_n = style ? wr : 1'b1;
        // Read data taken at the answer edge, before a clearing read moves them
        repeat (3) @(negedge mclk);
        q = dout;
        if (!wr && cs)
            chk("data_oe", data_oe, 1);
        repeat (3) @(negedge mclk);
        cs_n = 1;
        wr_n = 1;
        rd_n = 1;
        repeat (4) @(negedge mclk);
    endtask
    task frame(input logic [7:0] d);
        int i;
        tx_en = 0;
        bus(1, 1, uart_pin_pkg::ADDR_DATA, d);
        chk("idle", ser, 1);
        tx_en = 1;
        i = 0;
        while (ser !== 1'b0 && i < 100)
        begin
            @(negedge mclk);
            i++;
        end
        repeat (8) @(negedge mclk);
        chk("start", ser, 0);
        for (i = 0; i < 8; i++)
        begin
            repeat (16) @(negedge mclk);
            chk("bit", ser, d[i]);
        end
        repeat (16) @(negedge mclk);
        chk("stop", ser, 1);
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(negedge mclk);
        reset = 0;
        repeat (4) @(negedge mclk);
        chk("rts", rts_n, 1);
        chk("tx", tx_pin, 1);
        bus(0, 1, uart_pin_pkg::ADDR_MCR, 8'h02);
        chk("rts", rts_n, 1);
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h02);
        chk("rts", rts_n, 0);
        ring_cmd = 1;
        bus(1, 0, uart_pin_pkg::ADDR_MCR, 8'h00);
        chk("mcr", q, 8'h42);
        bus(1, 1, uart_pin_pkg::ADDR_IER, 8'h08);
        ring_cmd = 0;
        repeat (6) @(negedge mclk);
        chk("irq", irq_out, 1);
        chk("irq_oe", irq_oe, 1);
        bus(1, 0, uart_pin_pkg::ADDR_MSR, 8'h00);
        chk("msr", q, 8'h01);
        chk("irq", irq_out, 0);
        chk("irq_oe", irq_oe, 0);
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h22);
        chk("irq_oe", irq_oe, 1);
        chk("irq", irq_out, 0);
        rx_break = 1;
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h10);
        chk("tx_oe", tx_oe, 0);
        chk("rts", rts_n, 1);
        lb = 1;
        frame(8'h5a);
        rx_break = 0;
        lb = 0;
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h00);
        chk("tx_oe", tx_oe, 1);
        frame(8'ha5);
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h02);
        sleep = 1;
        repeat (6) @(negedge mclk);
        chk("power", {low_power, osc_enable, host_isolate}, 8'h05);
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h00);
        chk("rts", rts_n, 0);
        chk("power", low_power, 1);
        sleep = 0;
        repeat (8) @(negedge mclk);
        chk("power", low_power, 0);
        chk("rts", rts_n, 1);
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h02);
        chk("rts", rts_n, 0);
        mrst = 1;
        repeat (8) @(negedge mclk);
        mrst = 0;
        repeat (4) @(negedge mclk);
        chk("rts", rts_n, 1);
        // Strap only moves while reset holds
        reset = 1;
        style = 0;
        mrst = 1;
        repeat (16) @(negedge mclk);
        reset = 0;
        repeat (4) @(negedge mclk);
        chk("rts", rts_n, 1);
        bus(1, 1, uart_pin_pkg::ADDR_MCR, 8'h02);
        chk("rts", rts_n, 0);
        bus(1, 0, uart_pin_pkg::ADDR_MCR, 8'h00);
        chk("mcr", q, 8'h02);
        bus(1, 1, uart_pin_pkg::ADDR_IER, 8'h08);
        ring_cmd = 1;
        repeat (6) @(negedge mclk);
        ring_cmd = 0;
        repeat (6) @(negedge mclk);
        chk("irq", {irq_out, irq_oe}, 8'h01);
        mrst = 0;
        repeat (8) @(negedge mclk);
        mrst = 1;
        repeat (4) @(negedge mclk);
        chk("rts", rts_n, 1);
        wrap_up;
    end
endmodule
